// ==== rtl/srb_consts.svh ====
`ifndef SRB_CONSTS_SVH
`define SRB_CONSTS_SVH
// Array geometry
`define SRB_ROWS        32
`define SRB_ROW_W       18
`define SRB_TOTAL_BITS  576
// Register byte offsets
`define SRB_CTRL_OFF    4'h0
`define SRB_STATUS_OFF  4'h4
`define SRB_INITA_OFF   4'h8
`define SRB_INITD_OFF   4'hC
// Reset values
`define SRB_CTRL_RESET  13'h0000
`define SRB_INITA_RESET 5'h00
// Status field positions
`define SRB_ST_EMPTY    0
`define SRB_ST_FULL     1
`define SRB_ST_COUNT    4
// Bus responses
`define SRB_RESP_OKAY   2'h0
`define SRB_RESP_SLVERR 2'h2
// Read-during-write pattern for the unknown-output setting
`define SRB_UNDEF_WORD  18'h3FFFF
`endif

// ==== rtl/srb_pkg.sv ====
package srb_pkg;
    // Depth-by-width shapes of the array
    typedef enum logic [2:0] {SRB_W1, SRB_W2, SRB_W4, SRB_W8, SRB_W9, SRB_W16, SRB_W18} srb_shape_t;
    // Operating modes
    typedef enum logic [2:0] {SRB_SDP, SRB_SP, SRB_FIFO, SRB_ROM, SRB_SHIFT} srb_mode_t;
    // Control register, shape in the low bits
    typedef struct packed {
        logic       direct_en;
        logic       direct_right;
        logic       rdw_old;
        logic       out_bypass;
        logic       out_clk;
        logic       rd_clk;
        logic       wr_clk;
        srb_mode_t  mode;
        srb_shape_t shape;
    } srb_ctrl_t;
    // User write request
    typedef struct packed {
        logic        en;
        logic [1:0]  be;
        logic [8:0]  addr;
        logic [17:0] data;
    } srb_wr_req_t;
endpackage : srb_pkg

// ==== rtl/srb_ram.sv ====
// Functional notes
// - Array holds 576 bits, parity bits included.
// - Shapes 512x1, 256x2, 128x4, 64x8, 64x9, 32x16, 32x18 are selectable.
// - Modes simple dual-port, single-port, FIFO, ROM, shift register; no true dual-port.
// - Write enable, data and address registers share one selectable clock.
// - Read address, read enable and output registers use either clock.
// - Only the output register may be bypassed; input registers always used.
// - Input clear acts at once; memory output changes only at next edge.
// - Output clear resets output registers immediately, and the output too unless the output register is bypassed.
// - RAM or ROM contents can be preloaded before operation.
// - Sixteen direct inputs from each side cluster; outputs feed both sides.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`include "srb_consts.svh"

module srb_ram (
    // Clock, reset, enable
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 ce,
    // AXI4-Lite slave
    input  wire logic [3:0]           awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [3:0]           araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    // Strobes standing in for the two block clocks
    input  wire logic [1:0]           clk_tick,
    // Write side
    input  wire srb_pkg::srb_wr_req_t wr_req,
    input  wire logic [15:0]          direct_left,
    input  wire logic [15:0]          direct_right,
    // Read side
    input  wire logic                 rd_en,
    input  wire logic [8:0]           rd_addr,
    // Asynchronous clears
    input  wire logic                 in_clr,
    input  wire logic                 out_clr,
    // Read data towards both neighbour clusters
    output logic [17:0]               rd_data,
    output logic [17:0]               q_left,
    output logic [17:0]               q_right,
    // FIFO flags
    output logic                      fifo_empty,
    output logic                      fifo_full
);

    // Lanes per row, as a power of two
    function automatic logic [2:0] lane_log(input srb_pkg::srb_shape_t s);
        case (s)
            srb_pkg::SRB_W1: lane_log = 3'h4;
            srb_pkg::SRB_W2: lane_log = 3'h3;
            srb_pkg::SRB_W4: lane_log = 3'h2;
            srb_pkg::SRB_W8: lane_log = 3'h1;
            srb_pkg::SRB_W9: lane_log = 3'h1;
            default:         lane_log = 3'h0;
        endcase
    endfunction : lane_log

    // Bit mask and value of a word placed in its row
    function automatic logic [35:0] place(input srb_pkg::srb_shape_t s, input logic [3:0] lane,
                                          input logic [17:0] d, input logic [1:0] be);
        logic [4:0]  w;
        logic [15:0] m;
        w = 5'h10 >> lane_log(s);
        m = 16'((17'h1 << w) - 17'h1) << (lane * w);
        case (s)
            srb_pkg::SRB_W9:  place = lane[0] ? {18'h2FF00, d[8], 1'b0, d[7:0], 8'h00}
                                              : {18'h100FF, 1'b0, d[8], 8'h00, d[7:0]};
            srb_pkg::SRB_W18: place = {be[1], be[0], {8{be[1]}}, {8{be[0]}}, d};
            srb_pkg::SRB_W16: place = {2'b00, {8{be[1]}}, {8{be[0]}}, 2'b00, d[15:0]};
            default:          place = {2'b00, m, 2'b00, (d[15:0] << (lane * w)) & m};
        endcase
    endfunction : place

    // Word taken back out of its row
    function automatic logic [17:0] extract(input srb_pkg::srb_shape_t s, input logic [3:0] lane,
                                            input logic [17:0] r);
        logic [4:0]  w;
        logic [15:0] m;
        w = 5'h10 >> lane_log(s);
        m = 16'((17'h1 << w) - 17'h1);
        case (s)
            srb_pkg::SRB_W9:  extract = lane[0] ? {9'h000, r[17], r[15:8]} : {9'h000, r[16], r[7:0]};
            srb_pkg::SRB_W18: extract = r;
            srb_pkg::SRB_W16: extract = {2'b00, r[15:0]};
            default:          extract = {2'b00, (r[15:0] >> (lane * w)) & m};
        endcase
    endfunction : extract

    srb_pkg::srb_ctrl_t ctrl_reg;
    logic [17:0]        mem [`SRB_ROWS];
    logic [4:0]         inita_reg;
    logic               aw_v_reg, w_v_reg;
    logic [3:0]         aw_a_reg;
    logic [31:0]        w_d_reg;
    logic [3:0]         w_s_reg;
    logic               wen_reg, ren_reg;
    logic [8:0]         waddr_reg, raddr_reg;
    logic [17:0]        wdat_reg, mem_q, out_reg;
    logic [1:0]         wbe_reg;
    logic [8:0]         wptr_reg, rptr_reg, sptr_reg;
    logic [9:0]         count_reg;
    logic               wr_tick, rd_tick, o_tick, wr_do;
    logic               is_fifo, is_shift, wen_ok, ren_ok;
    logic [8:0]         wa_sel, ra_sel, ptr_mask;
    logic [17:0]        wd_sel;
    logic [9:0]         depth;
    logic [35:0]        wr_place;
    logic [4:0]         w_row, r_row;
    logic [31:0]        rd_mux;
    logic               rd_hit;

    // Each register group follows its selected clock strobe
    assign wr_tick = ce & clk_tick[ctrl_reg.wr_clk];
    assign rd_tick = ce & clk_tick[ctrl_reg.rd_clk];
    assign o_tick  = ce & clk_tick[ctrl_reg.out_clk];

    // Depth follows the shape; 32 rows of 18 bits give the full capacity
    assign depth    = 10'h020 << lane_log(ctrl_reg.shape);
    assign ptr_mask = 9'(depth - 10'h001);
    assign is_fifo  = ctrl_reg.mode == srb_pkg::SRB_FIFO;
    assign is_shift = ctrl_reg.mode == srb_pkg::SRB_SHIFT;
    assign fifo_empty = count_reg == 10'h000;
    assign fifo_full  = count_reg == depth;

    // Address and enable sources per mode; ROM refuses user writes
    always_comb begin
        wen_ok = wr_req.en && ctrl_reg.mode != srb_pkg::SRB_ROM && !(is_fifo && fifo_full);
        ren_ok = is_shift ? wr_req.en : rd_en && !(is_fifo && fifo_empty);
        case (ctrl_reg.mode)
            srb_pkg::SRB_SP: begin
                wa_sel = wr_req.addr;
                ra_sel = wr_req.addr;
            end
            srb_pkg::SRB_FIFO: begin
                wa_sel = wptr_reg;
                ra_sel = rptr_reg;
            end
            srb_pkg::SRB_SHIFT: begin
                wa_sel = sptr_reg;
                ra_sel = sptr_reg;     // Tap reads the oldest word before it is replaced when rdw_old is set
            end
            default: begin
                wa_sel = wr_req.addr;
                ra_sel = rd_addr;
            end
        endcase
    end

    // Low data may come straight from a neighbour cluster
    assign wd_sel = ctrl_reg.direct_en
                  ? {wr_req.data[17:16], ctrl_reg.direct_right ? direct_right : direct_left}
                  : wr_req.data;

    // Write-side input registers, always in the path
    always_ff @(posedge aclk or posedge in_clr) begin
        if (in_clr) begin
            wen_reg   <= 1'b0;
            waddr_reg <= 9'h000;
            wdat_reg  <= 18'h00000;
            wbe_reg   <= 2'h0;
        end else if (!aresetn) begin
            wen_reg   <= 1'b0;
            waddr_reg <= 9'h000;
            wdat_reg  <= 18'h00000;
            wbe_reg   <= 2'h0;
        end else if (wr_tick) begin
            wen_reg   <= wen_ok;
            waddr_reg <= wa_sel;
            wdat_reg  <= wd_sel;
            wbe_reg   <= wr_req.be;
        end
    end

    // Read-side input registers, always in the path
    always_ff @(posedge aclk or posedge in_clr) begin
        if (in_clr) begin
            ren_reg   <= 1'b0;
            raddr_reg <= 9'h000;
        end else if (!aresetn) begin
            ren_reg   <= 1'b0;
            raddr_reg <= 9'h000;
        end else if (rd_tick) begin
            ren_reg   <= ren_ok;
            raddr_reg <= ra_sel;
        end
    end

    // FIFO and shift pointers; occupancy moves on either side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr_reg  <= 9'h000;
            rptr_reg  <= 9'h000;
            sptr_reg  <= 9'h000;
            count_reg <= 10'h000;
        end else if (ce) begin
            if (wr_tick && wen_ok && is_fifo) begin
                wptr_reg <= (wptr_reg + 9'h001) & ptr_mask;
            end
            if (rd_tick && ren_ok && is_fifo) begin
                rptr_reg <= (rptr_reg + 9'h001) & ptr_mask;
            end
            if (wr_tick && wr_req.en && is_shift) begin
                sptr_reg <= (sptr_reg + 9'h001) & ptr_mask;
            end
            count_reg <= count_reg + 10'(wr_tick && wen_ok && is_fifo) - 10'(rd_tick && ren_ok && is_fifo);
        end
    end

    assign wr_place = place(ctrl_reg.shape, 4'(waddr_reg & ~(9'h1FF << lane_log(ctrl_reg.shape))),
                            wdat_reg, wbe_reg);
    assign w_row = 5'(waddr_reg >> lane_log(ctrl_reg.shape));
    assign r_row = 5'(raddr_reg >> lane_log(ctrl_reg.shape));
    assign rd_hit = wr_tick && wen_reg && w_row == r_row;

    // Array; a bus preload wins over a user write to the same row.
    // Contents are not reset, so software must preload before reading.
    always_ff @(posedge aclk) begin
        if (ce) begin
            if (wr_tick && wen_reg) begin
                mem[w_row] <= (mem[w_row] & ~wr_place[35:18]) | (wr_place[17:0] & wr_place[35:18]);
            end
            if (wr_do && aw_a_reg == `SRB_INITD_OFF && w_s_reg != 4'h0) begin
                mem[inita_reg] <= w_d_reg[17:0];
            end
        end
    end

    // Array output latch: an input clear shows here only at the next edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_q <= 18'h00000;
        end else if (rd_tick && ren_reg) begin
            if (rd_hit && !ctrl_reg.rdw_old) begin
                mem_q <= `SRB_UNDEF_WORD;
            end else begin
                mem_q <= extract(ctrl_reg.shape, 4'(raddr_reg & ~(9'h1FF << lane_log(ctrl_reg.shape))),
                                 mem[r_row]);
            end
        end
    end

    // Output register, cleared the moment the clear rises
    always_ff @(posedge aclk or posedge out_clr) begin
        if (out_clr) begin
            out_reg <= 18'h00000;
        end else if (!aresetn) begin
            out_reg <= 18'h00000;
        end else if (o_tick) begin
            out_reg <= mem_q;
        end
    end

    // Only the output register has a bypass
    assign rd_data = ctrl_reg.out_bypass ? mem_q : out_reg;
    assign q_left  = rd_data;
    assign q_right = rd_data;

    // Bus handshakes: one address and one data slot, freed by the response
    assign awready = ce & ~aw_v_reg;
    assign wready  = ce & ~w_v_reg;
    assign arready = ce & ~rvalid;
    assign wr_do   = ce & aw_v_reg & w_v_reg & ~bvalid;

    // Write address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_v_reg <= 1'b0;
            w_v_reg  <= 1'b0;
            aw_a_reg <= 4'h0;
            w_d_reg  <= 32'h00000000;
            w_s_reg  <= 4'h0;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_v_reg <= 1'b1;
                aw_a_reg <= awaddr;
            end else if (wr_do) begin
                aw_v_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_v_reg <= 1'b1;
                w_d_reg <= wdata;
                w_s_reg <= wstrb;
            end else if (wr_do) begin
                w_v_reg <= 1'b0;
            end
        end
    end

    // Register writes; preload address steps after each data word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg  <= `SRB_CTRL_RESET;
            inita_reg <= `SRB_INITA_RESET;
        end else if (wr_do) begin
            case (aw_a_reg)
                `SRB_CTRL_OFF: begin
                    if (w_s_reg[0]) ctrl_reg[7:0]  <= w_d_reg[7:0];
                    if (w_s_reg[1]) ctrl_reg[12:8] <= w_d_reg[12:8];
                end
                `SRB_INITA_OFF: begin
                    if (w_s_reg[0]) inita_reg <= w_d_reg[4:0];
                end
                `SRB_INITD_OFF: begin
                    if (w_s_reg != 4'h0) inita_reg <= inita_reg + 5'h01;
                end
                default: begin
                end
            endcase
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `SRB_RESP_OKAY;
        end else if (wr_do) begin
            bvalid <= 1'b1;
            bresp  <= (aw_a_reg == `SRB_STATUS_OFF) ? `SRB_RESP_SLVERR : `SRB_RESP_OKAY;
        end else if (ce && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read decode; unused bits read zero
    always_comb begin
        rd_mux = 32'h00000000;
        case (araddr)
            `SRB_CTRL_OFF:   rd_mux = {19'h00000, ctrl_reg};
            `SRB_STATUS_OFF: begin
                rd_mux[`SRB_ST_EMPTY] = fifo_empty;
                rd_mux[`SRB_ST_FULL]  = fifo_full;
                rd_mux[`SRB_ST_COUNT +: 10] = count_reg;
            end
            `SRB_INITA_OFF:  rd_mux = {27'h0000000, inita_reg};
            `SRB_INITD_OFF:  rd_mux = {14'h0000, mem[inita_reg]};
            default:         rd_mux = 32'h00000000;
        endcase
    end

    // Read response, one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= `SRB_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_mux;
            rresp  <= `SRB_RESP_OKAY;
        end else if (ce && rready) begin
            rvalid <= 1'b0;
        end
    end

    // Remembers that an input clear struck since the last edge; a short pulse is never sampled itself
    logic clr_seen_reg;
    always_ff @(posedge aclk or posedge in_clr) begin
        if (in_clr) begin
            clr_seen_reg <= 1'b1;
        end else begin
            clr_seen_reg <= 1'b0;
        end
    end

    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_issue;
        wr_tick && wen_ok;
    endsequence

    sequence rd_issue;
        rd_tick && ren_ok && !in_clr;
    endsequence

    property capture_wr;
        wr_issue |=> clr_seen_reg || (wen_reg && waddr_reg == $past(wa_sel));
    endproperty

    property collide_unknown;
        rd_tick && ren_reg && rd_hit && !ctrl_reg.rdw_old |=> mem_q == `SRB_UNDEF_WORD;
    endproperty

    wr_capture_a: assert property (capture_wr) else $error("write registers missed a request");
    rd_capture_a: assert property (rd_issue |=> clr_seen_reg || (ren_reg && raddr_reg == $past(ra_sel)))
        else $error("read registers missed a request");
    rom_guard_a: assert property (ctrl_reg.mode == srb_pkg::SRB_ROM |-> !wen_ok)
        else $error("user write accepted in ROM mode");
    bypass_path_a: assert property (ctrl_reg.out_bypass |-> rd_data == mem_q)
        else $error("bypass does not show array output");
    out_clear_a: assert property (out_clr && !ctrl_reg.out_bypass |-> rd_data == 18'h00000)
        else $error("output clear not seen on output");
    in_clear_a: assert property (clr_seen_reg |-> !wen_reg && !ren_reg && waddr_reg == 9'h000 && raddr_reg == 9'h000)
        else $error("input clear did not clear registers");
    in_clear_q_a: assert property (clr_seen_reg |=> $stable(mem_q))
        else $error("array output moved without read edge");
    collide_rdw_a: assert property (collide_unknown) else $error("collision did not give unknown word");
    fifo_depth_a: assert property (count_reg <= depth) else $error("FIFO count beyond depth");
    power_up_a: assert property (@(posedge aclk) disable iff (1'b0)
        $rose(aresetn) |-> rd_data == 18'h00000) else $error("output not cleared after reset");

endmodule : srb_ram

// ==== bench/srb_user_model.sv ====
// Neighbouring user logic that drives the write and read sides of the block
module srb_user_model (
    // Clock
    input  wire logic            aclk,
    // Requests towards the block
    output srb_pkg::srb_wr_req_t wr_req,
    output logic                 rd_en,
    output logic [8:0]           rd_addr,
    // Read data back from the block
    input  wire logic [17:0]     rd_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle lines start released
    initial begin
        wr_req  = '0;
        rd_en   = 1'b0;
        rd_addr = 9'h1FF;
    end

    // One write word per tick, enable and clock from local logic
    task automatic wr(input logic [8:0] a, input logic [17:0] d, input logic [1:0] be);
        @(posedge aclk);
        wr_req <= '{en: 1'b1, be: be, addr: a, data: d};
        @(posedge aclk);
        // Released lines show the inverse so a stale copy cannot pass
        wr_req <= '{en: 1'b0, be: 2'h0, addr: ~a, data: ~d};
    endtask : wr

    // Read with a latency of lat edges after the request is driven
    task automatic rd(input logic [8:0] a, input int lat, output logic [17:0] q);
        @(posedge aclk);
        rd_en   <= 1'b1;
        rd_addr <= a;
        @(posedge aclk);
        rd_en   <= 1'b0;
        rd_addr <= ~a;
        repeat (lat - 1) @(posedge aclk);
        #1 q = rd_data;
    endtask : rd
endmodule : srb_user_model

// ==== bench/srb_ram_tb.sv ====
`include "srb_consts.svh"

module srb_ram_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic aclk = 0, aresetn = 0, ce = 1, in_clr = 0, out_clr = 0;
    logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata;
    logic awready, wready, bvalid, arready, rvalid, rd_en, fifo_empty, fifo_full;
    logic [1:0] bresp, rresp, clk_tick = 2'h3;
    logic [15:0] direct_left = 0, direct_right = 0;
    logic [8:0] rd_addr;
    logic [17:0] rd_data, q_left, q_right, mem_m [32];
    srb_pkg::srb_wr_req_t wr_req;
    int fail_count = 0, checks_done = 0, cycles = 0;
    logic [31:0] seed = 32'h0000EEF1;

    // Clock at 100 MHz
    always #5 aclk = ~aclk;

    srb_ram dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .clk_tick, .wr_req, .direct_left, .direct_right, .rd_en, .rd_addr, .in_clr, .out_clr,
        .rd_data, .q_left, .q_right, .fifo_empty, .fifo_full);
    srb_user_model u_user (.aclk, .wr_req, .rd_en, .rd_addr, .rd_data);

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    // Master holds each channel until its ready edge, both offered together
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hF;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp; bready <= 1'b0; break;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata; check("rresp", rresp, `SRB_RESP_OKAY); rready <= 1'b0; break;
            end
        end
    endtask : axi_rd

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        logic [31:0] v;
        logic [1:0] r;
        logic [17:0] q;
        logic [17:0] fq [$];
        direct_left = 16'(xorshift());
        direct_right = 16'(xorshift());
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        #1 check("rd_data_reset", rd_data, 0);
        check("empty_reset", fifo_empty, 1);
        axi_rd(`SRB_CTRL_OFF, v);
        check("ctrl_reset", v, 0);
        // Every shape and mode code is accepted and reads back
        for (int i = 0; i < 7; i++) begin
            axi_wr(`SRB_CTRL_OFF, ((i % 5) << 3) | i, r);
            axi_rd(`SRB_CTRL_OFF, v);
            check("ctrl_rb", v, ((i % 5) << 3) | i);
        end
        axi_wr(`SRB_STATUS_OFF, 32'h3, r);
        check("status_wr", r, `SRB_RESP_SLVERR);
        axi_wr(`SRB_CTRL_OFF, 32'h6, r);
        // Fill all rows of the widest shape and read them all back
        for (int a = 0; a < 32; a++) begin
            v = xorshift();
            mem_m[a] = v[17:0];
            u_user.wr(a, v[17:0], 2'b11);
        end
        for (int a = 0; a < 32; a++) begin
            u_user.rd(a, 3, q);
            check("row", q, mem_m[a]);
            check("q_left", q_left, mem_m[a]);
            check("q_right", q_right, mem_m[a]);
        end
        // No byte lanes enabled writes nothing
        u_user.wr(3, ~mem_m[3], 2'b00);
        u_user.rd(3, 3, q);
        check("be_off", q, mem_m[3]);
        // Output register bypassed, one edge sooner
        axi_wr(`SRB_CTRL_OFF, 32'h206, r);
        u_user.rd(7, 2, q);
        check("bypass", q, mem_m[7]);
        axi_wr(`SRB_CTRL_OFF, 32'h6, r);
        // Input clear between capture and array write drops the write
        u_user.wr(9, ~mem_m[9], 2'b11);
        #1 in_clr = 1'b1;
        #1 check("clr_hold", rd_data, mem_m[7]);
        in_clr = 1'b0;
        u_user.rd(9, 3, q);
        check("in_clr", q, mem_m[9]);
        // Output clear acts without a clock edge
        #2 out_clr = 1'b1;
        #1 check("out_clr", rd_data, 0);
        // Held across one edge so the output stays cleared while the clear stands
        @(posedge aclk);
        #1 out_clr = 1'b0;
        // Bus preload of a row, address steps on
        axi_wr(`SRB_INITA_OFF, 32'hC, r);
        v = xorshift();
        axi_wr(`SRB_INITD_OFF, v, r);
        mem_m[12] = v[17:0];
        u_user.rd(12, 3, q);
        check("preload", q, mem_m[12]);
        axi_rd(`SRB_INITA_OFF, v);
        check("inita_inc", v, 32'hD);
        // Write side follows only the selected clock
        axi_wr(`SRB_CTRL_OFF, 32'h46, r);
        for (int t = 1; t < 3; t++) begin
            clk_tick <= t[1:0];
            v = xorshift();
            u_user.wr(14, v[17:0], 2'b11);
            if (t == 2) mem_m[14] = v[17:0];
            repeat (2) @(posedge aclk);
            clk_tick <= 2'h3;
            u_user.rd(14, 3, q);
            check("wr_clk_sel", q, mem_m[14]);
        end
        // Low data taken from a neighbour cluster, left then right
        for (int o = 0; o < 2; o++) begin
            axi_wr(`SRB_CTRL_OFF, o ? 32'h1806 : 32'h1006, r);
            v = xorshift();
            u_user.wr(27, v[17:0], 2'b11);
            mem_m[27] = {v[17:16], o ? direct_right : direct_left};
            u_user.rd(27, 3, q);
            check("direct", q, mem_m[27]);
        end
        // Writes refused in ROM mode
        axi_wr(`SRB_CTRL_OFF, 32'h1E, r);
        u_user.wr(20, ~mem_m[20], 2'b11);
        axi_wr(`SRB_CTRL_OFF, 32'h6, r);
        u_user.rd(20, 3, q);
        check("rom_write", q, mem_m[20]);
        // Read and write of one row at the same edge
        for (int o = 0; o < 2; o++) begin
            axi_wr(`SRB_CTRL_OFF, o ? 32'h406 : 32'h6, r);
            v = xorshift();
            fork
                u_user.wr(25, v[17:0], 2'b11);
                u_user.rd(25, 3, q);
            join
            check("rdw", q, o ? mem_m[25] : `SRB_UNDEF_WORD);
            mem_m[25] = v[17:0];
        end
        // FIFO: the word past the depth is refused, words leave in order
        axi_wr(`SRB_CTRL_OFF, 32'h16, r);
        for (int a = 0; a < 33; a++) begin
            v = xorshift();
            if (a < 32) fq.push_back(v[17:0]);
            u_user.wr(0, v[17:0], 2'b11);
        end
        axi_rd(`SRB_STATUS_OFF, v);
        check("fifo_status", v, (32'h20 << `SRB_ST_COUNT) | (32'h1 << `SRB_ST_FULL));
        while (fq.size() > 0) begin
            u_user.rd(0, 3, q);
            check("fifo_word", q, fq.pop_front());
        end
        check("fifo_empty", fifo_empty, 1);
        results();
    end
endmodule : srb_ram_tb
